/* File: src/tmw_timer8.sv */
// 8-bit timer with waveform generation and two compare-output channels
// assumes a plain strobe register port; tick pin is asynchronous to clk_sys
//
// Overview of operation
// [R1] counter synchronous to clk_sys, timer tick is only an enable
// [R2] nonzero channel A mode routes wave to pin; direction bit enables driver
// [R3] non-PWM A modes: off, toggle, clear, set on match
// [R4] fast PWM A: 10 clear/set-bottom, 11 inverse, 01 toggle if mode high bit
// [R5] phase PWM A: 10 clear up/set down, 11 inverse, 01 toggle if high bit
// [R6] nonzero channel B mode routes wave to pin; direction bit enables driver
// [R7] non-PWM B modes: off, toggle, clear, set on match
// [R8] fast PWM B: 10 clear/set-bottom, 11 inverse, 01 reserved
// [R9] phase PWM B: 10 clear up/set down, 11 inverse, 01 reserved
// [R10] fast PWM, compare equals TOP with high bit: ignore match, act at bottom
// [R11] phase PWM, compare equals TOP with high bit: ignore match, act at TOP
// [R12] control register bits 3 and 2 ignore writes, read zero
// [R13] three-bit waveform mode from two low bits plus high bit
// [R14] mode decode and TOP source per mode
// [R15] compare buffer update point and overflow flag point per mode
// [R16] clock select: stop, divide 1, 8, 64, 256, 1024, pin edges
// [R17] fast PWM counts up to TOP then returns to zero
// [R18] phase PWM counts up, holds TOP one tick, counts down
// [R19] counter write blocks compare match on the next tick
// [R20] reserved codes disconnect output and cause no action; reserved waveform modes still set match flags when count equals compare
// [R21] match, overflow and TOP events taken only on tick cycles
`timescale 1ns/1ps
module tmw_timer8 (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [5:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       tick_pin,
   input  wire logic       dir_a,
   input  wire logic       dir_b,
   output logic            chan_a_wave_out,
   output logic            chan_b_wave_out,
   output logic            chan_a_pin_en,
   output logic            chan_b_pin_en
);
   typedef struct packed {
      logic [7:0] ctl_a;
      logic [7:0] ctl_b;
      logic [7:0] cnt;
      logic [7:0] cmp_a_buf;
      logic [7:0] cmp_b_buf;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [7:0] flags;
      logic       down;
      logic       blk;
      logic       wa;
      logic       wb;
      logic       ena;
      logic       enb;
      logic [7:0] rdata;
      logic [1:0] pin_sync;
   } tmw_state_t;

   tmw_state_t st_reg;
   tmw_state_t st_next;
   logic       timer_tick;

   tmw_tick_gen u_tick (
      .clk_sys            (clk_sys),
      .rst_n              (rst_n),
      .tick_source_select (st_reg.ctl_b[tmw_pkg::CS_HI:tmw_pkg::CS_LO]), // R16
      .ext_sync           (st_reg.pin_sync[1]),
      .timer_tick         (timer_tick)
   );

   tmw_pkg::tmw_wmode_t wmode;
   logic [1:0] om_a;
   logic [1:0] om_b;
   logic [7:0] top;
   logic       is_fast;
   logic       is_pc;
   logic       is_rsv;
   logic       at_top;
   logic       at_bot;
   logic       hit_a;
   logic       hit_b;
   logic       frc_a;
   logic       frc_b;
   logic       upd;
   logic       ovf;
   logic       cnt_wr;

   function automatic logic wave_step(input logic cur, input logic [1:0] om, input logic hit, input logic up,
                                      input logic fast, input logic pc, input logic bot, input logic tgl_ok,
                                      input logic at_t, input logic cmp_top);
      logic nv;
      nv = cur;
      if (!fast && !pc) begin
         if (hit) begin
            unique case (om)
               tmw_pkg::OM_OFF: nv = cur;
               tmw_pkg::OM_TGL: nv = ~cur;
               tmw_pkg::OM_CLR: nv = 1'b0;
               tmw_pkg::OM_SET: nv = 1'b1;
            endcase
         end
      end else if (om == tmw_pkg::OM_TGL) begin
         if (tgl_ok && hit) begin
            nv = ~cur;
         end
      end else if (om[1]) begin
         if (fast) begin
            if (hit && !cmp_top) begin
               nv = om[0];
            end
            if (bot) begin
               nv = ~om[0];
            end
         end else if (cmp_top) begin
            // level at TOP matches a down-counting match, keeps symmetry
            if (at_t) begin
               nv = ~om[0];
            end
         end else if (hit) begin
            nv = up ? om[0] : ~om[0];
         end
      end
      return nv;
   endfunction : wave_step

   always_comb begin
      wmode   = tmw_pkg::tmw_wmode_t'({st_reg.ctl_b[tmw_pkg::WMH],
                                       st_reg.ctl_a[tmw_pkg::WML_HI:tmw_pkg::WML_LO]}); // R13
      om_a    = st_reg.ctl_a[tmw_pkg::CHA_HI:tmw_pkg::CHA_LO];
      om_b    = st_reg.ctl_a[tmw_pkg::CHB_HI:tmw_pkg::CHB_LO];
      is_fast = (wmode == tmw_pkg::WM_FAST_FF) || (wmode == tmw_pkg::WM_FAST_A);
      is_pc   = (wmode == tmw_pkg::WM_PC_FF) || (wmode == tmw_pkg::WM_PC_A);
      is_rsv  = (wmode == tmw_pkg::WM_RSV4) || (wmode == tmw_pkg::WM_RSV6);
      top     = (wmode == tmw_pkg::WM_CTC || wmode == tmw_pkg::WM_PC_A || wmode == tmw_pkg::WM_FAST_A)
                ? st_reg.cmp_a : tmw_pkg::CNT_MAX; // R14
      cnt_wr  = reg_wr && (reg_addr == tmw_pkg::OFS_CNT);
      at_top  = timer_tick && (st_reg.cnt == top); // R21
      at_bot  = timer_tick && (st_reg.cnt == tmw_pkg::CNT_BOTTOM);
      hit_a   = timer_tick && !st_reg.blk && (st_reg.cnt == st_reg.cmp_a); // R19 R21
      hit_b   = timer_tick && !st_reg.blk && (st_reg.cnt == st_reg.cmp_b); // R19 R21
      frc_a   = reg_wr && (reg_addr == tmw_pkg::OFS_TCB) && reg_wdata[tmw_pkg::FRC_A] && !is_fast && !is_pc;
      frc_b   = reg_wr && (reg_addr == tmw_pkg::OFS_TCB) && reg_wdata[tmw_pkg::FRC_B] && !is_fast && !is_pc;
      // R15 buffer update point
      upd     = (is_pc && at_top) || (is_fast && at_top);
      // R15 overflow point
      if (is_pc) begin
         ovf = at_bot;
      end else if (wmode == tmw_pkg::WM_FAST_A) begin
         ovf = at_top;
      end else begin
         ovf = timer_tick && (st_reg.cnt == tmw_pkg::CNT_MAX) && !is_rsv;
      end

      st_next          = st_reg;
      st_next.pin_sync = {st_reg.pin_sync[0], tick_pin};
      st_next.rdata    = tmw_pkg::RESET_BYTE;
      st_next.blk      = timer_tick ? 1'b0 : st_reg.blk;

      // counting sequence, advanced only on tick R1
      if (timer_tick && !is_rsv) begin
         if (is_pc) begin // R18
            if (st_reg.cnt == top) begin
               st_next.down = 1'b1;
               st_next.cnt  = st_reg.cnt - tmw_pkg::CNT_ONE;
            end else if (st_reg.down && st_reg.cnt != tmw_pkg::CNT_BOTTOM) begin
               st_next.cnt  = st_reg.cnt - tmw_pkg::CNT_ONE;
            end else begin
               st_next.down = 1'b0;
               st_next.cnt  = st_reg.cnt + tmw_pkg::CNT_ONE;
            end
         end else begin
            st_next.down = 1'b0;
            st_next.cnt  = (st_reg.cnt == top) ? tmw_pkg::CNT_BOTTOM : st_reg.cnt + tmw_pkg::CNT_ONE; // R17
         end
      end

      // compare buffers R15
      if (!is_fast && !is_pc) begin
         st_next.cmp_a = st_reg.cmp_a_buf;
         st_next.cmp_b = st_reg.cmp_b_buf;
      end else if (upd) begin
         st_next.cmp_a = st_reg.cmp_a_buf;
         st_next.cmp_b = st_reg.cmp_b_buf;
      end

      // waveform outputs; reserved modes leave them idle R20
      if (!is_rsv) begin
         st_next.wa = wave_step(st_reg.wa, om_a, hit_a | frc_a, !st_reg.down, is_fast, is_pc,
                                is_fast && at_top, st_reg.ctl_b[tmw_pkg::WMH],
                                at_top, st_reg.cmp_a == top); // R3 R4 R5 R10 R11
         st_next.wb = wave_step(st_reg.wb, om_b, hit_b | frc_b, !st_reg.down, is_fast, is_pc,
                                is_fast && at_top, 1'b0,
                                at_top, st_reg.cmp_b == top); // R7 R8 R9 R10 R11 R20
      end
      st_next.ena = (om_a != tmw_pkg::OM_OFF) && dir_a && !is_rsv
                    && !((is_fast || is_pc) && om_a == tmw_pkg::OM_TGL && !st_reg.ctl_b[tmw_pkg::WMH]); // R2 R4 R5
      st_next.enb = (om_b != tmw_pkg::OM_OFF) && dir_b && !is_rsv
                    && !((is_fast || is_pc) && om_b == tmw_pkg::OM_TGL); // R6 R20

      // flags: hardware set wins over software clear
      st_next.flags[tmw_pkg::FLG_OVF] = ovf |
         (st_reg.flags[tmw_pkg::FLG_OVF] & ~(reg_wr && reg_addr == tmw_pkg::OFS_FLAG && reg_wdata[tmw_pkg::FLG_OVF]));
      st_next.flags[tmw_pkg::FLG_MA] = hit_a |
         (st_reg.flags[tmw_pkg::FLG_MA] & ~(reg_wr && reg_addr == tmw_pkg::OFS_FLAG && reg_wdata[tmw_pkg::FLG_MA]));
      st_next.flags[tmw_pkg::FLG_MB] = hit_b |
         (st_reg.flags[tmw_pkg::FLG_MB] & ~(reg_wr && reg_addr == tmw_pkg::OFS_FLAG && reg_wdata[tmw_pkg::FLG_MB]));

      if (reg_wr) begin
         unique case (reg_addr)
            tmw_pkg::OFS_WOCA: st_next.ctl_a = reg_wdata & tmw_pkg::WOCA_MASK; // R12
            tmw_pkg::OFS_TCB:  st_next.ctl_b = reg_wdata & tmw_pkg::TCB_MASK;
            tmw_pkg::OFS_CNT: begin
               st_next.cnt = reg_wdata;
               st_next.blk = 1'b1; // R19
            end
            tmw_pkg::OFS_CMPA: st_next.cmp_a_buf = reg_wdata;
            tmw_pkg::OFS_CMPB: st_next.cmp_b_buf = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            tmw_pkg::OFS_WOCA: st_next.rdata = st_reg.ctl_a & tmw_pkg::WOCA_MASK; // R12
            tmw_pkg::OFS_TCB:  st_next.rdata = st_reg.ctl_b & tmw_pkg::TCB_MASK;
            tmw_pkg::OFS_CNT:  st_next.rdata = st_reg.cnt;
            tmw_pkg::OFS_CMPA: st_next.rdata = st_reg.cmp_a_buf;
            tmw_pkg::OFS_CMPB: st_next.rdata = st_reg.cmp_b_buf;
            tmw_pkg::OFS_FLAG: st_next.rdata = st_reg.flags & tmw_pkg::FLAG_MASK;
            default:           st_next.rdata = tmw_pkg::RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata       = st_reg.rdata;
   assign chan_a_wave_out = st_reg.wa;
   assign chan_b_wave_out = st_reg.wb;
   assign chan_a_pin_en   = st_reg.ena;
   assign chan_b_pin_en   = st_reg.enb;
endmodule : tmw_timer8

/* File: src/tmw_pkg.sv */
// package for the 8-bit timer waveform/output control block
// assumes a single system clock; registers reached over a plain strobe port
package tmw_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   // register offsets
   localparam logic [5:0] OFS_WOCA = 6'h30;
   localparam logic [5:0] OFS_TCB  = 6'h33;
   localparam logic [5:0] OFS_CNT  = 6'h32;
   localparam logic [5:0] OFS_CMPA = 6'h36;
   localparam logic [5:0] OFS_CMPB = 6'h3C;
   localparam logic [5:0] OFS_FLAG = 6'h38;
   // field positions
   localparam int unsigned CHA_HI = 7;
   localparam int unsigned CHA_LO = 6;
   localparam int unsigned CHB_HI = 5;
   localparam int unsigned CHB_LO = 4;
   localparam int unsigned WML_HI = 1;
   localparam int unsigned WML_LO = 0;
   localparam int unsigned FRC_A  = 7;
   localparam int unsigned FRC_B  = 6;
   localparam int unsigned WMH    = 3;
   localparam int unsigned CS_HI  = 2;
   localparam int unsigned CS_LO  = 0;
   localparam int unsigned FLG_OVF = 0;
   localparam int unsigned FLG_MA  = 1;
   localparam int unsigned FLG_MB  = 2;
   // writable masks and reset values
   localparam logic [7:0] WOCA_MASK  = 8'hF3;
   localparam logic [7:0] TCB_MASK   = 8'h0F;
   localparam logic [7:0] FLAG_MASK  = 8'h07;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_ONE    = 8'h01;
   // output-mode codes
   localparam logic [1:0] OM_OFF = 2'h0;
   localparam logic [1:0] OM_TGL = 2'h1;
   localparam logic [1:0] OM_CLR = 2'h2;
   localparam logic [1:0] OM_SET = 2'h3;
   // prescaler
   localparam int unsigned PRE_W = 10;
   localparam logic [9:0] PRE_8    = 10'h007;
   localparam logic [9:0] PRE_64   = 10'h03F;
   localparam logic [9:0] PRE_256  = 10'h0FF;
   localparam logic [9:0] PRE_1024 = 10'h3FF;
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_D64  = 3'h3;
   localparam logic [2:0] CS_D256 = 3'h4;
   localparam logic [2:0] CS_D1K  = 3'h5;
   localparam logic [2:0] CS_EXTF = 3'h6;
   localparam logic [2:0] CS_EXTR = 3'h7;

   typedef enum logic [2:0] {
      WM_NORMAL, WM_PC_FF, WM_CTC, WM_FAST_FF, WM_RSV4, WM_PC_A, WM_RSV6, WM_FAST_A
   } tmw_wmode_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } tmw_bus_t;

   typedef struct packed {
      logic wave_a;
      logic wave_b;
      logic en_a;
      logic en_b;
   } tmw_pins_t;
endpackage : tmw_pkg

/* File: src/tmw_tick_gen.sv */
// tick generator: prescaler and external edge source for the timer
// assumes ext_sync already passed a two-stage synchroniser in the caller
`timescale 1ns/1ps
module tmw_tick_gen #(
   parameter int unsigned PRE_W = tmw_pkg::PRE_W
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [2:0] tick_source_select,
   input  wire logic       ext_sync,
   output logic            timer_tick
);
   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic             ext_d;
      logic             tick;
   } tmw_tick_st_t;

   tmw_tick_st_t st_reg;
   tmw_tick_st_t st_next;

   always_comb begin
      st_next       = st_reg;
      st_next.pre   = st_reg.pre + PRE_W'(1);
      st_next.ext_d = ext_sync;
      unique case (tick_source_select)
         tmw_pkg::CS_STOP: st_next.tick = 1'b0;
         tmw_pkg::CS_DIV1: st_next.tick = 1'b1;
         tmw_pkg::CS_DIV8: st_next.tick = (st_reg.pre[2:0] == tmw_pkg::PRE_8[2:0]);
         tmw_pkg::CS_D64:  st_next.tick = (st_reg.pre[5:0] == tmw_pkg::PRE_64[5:0]);
         tmw_pkg::CS_D256: st_next.tick = (st_reg.pre[7:0] == tmw_pkg::PRE_256[7:0]);
         tmw_pkg::CS_D1K:  st_next.tick = (st_reg.pre == tmw_pkg::PRE_1024);
         tmw_pkg::CS_EXTF: st_next.tick = st_reg.ext_d & ~ext_sync;
         tmw_pkg::CS_EXTR: st_next.tick = ~st_reg.ext_d & ext_sync;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign timer_tick = st_reg.tick;
endmodule : tmw_tick_gen

/* File: tb/tmw_timer8_checker.sv */
// checker: register port and pin-enable relations of the timer block
// assumes it is bound to tmw_timer8 and sees its ports only
`timescale 1ns/1ps
module tmw_timer8_checker (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       dir_a,
   input wire logic       dir_b,
   input wire logic       chan_a_pin_en,
   input wire logic       chan_b_pin_en
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [1:0] wml_reg;
   // low mode bits as last written
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wml_reg <= 2'h0;
      end else if (reg_wr && reg_addr == 6'h30) begin
         wml_reg <= reg_wdata[1:0];
      end
   end
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_ctl_rsvd_zero: assert property (reg_rd && reg_addr == 6'h30 |=> reg_rdata[3:2] == 2'h0)
      else $error("reserved control bits read nonzero");
   a_ctl_readback: assert property ((reg_wr && reg_addr == 6'h30) ##1 (reg_rd && reg_addr == 6'h30)
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'hF3)) else $error("control readback wrong");
   a_dir_gates_a: assert property (!dir_a |=> !chan_a_pin_en)
      else $error("channel a drives with direction off");
   a_dir_gates_b: assert property (!dir_b |=> !chan_b_pin_en)
      else $error("channel b drives with direction off");
   a_off_mode_a: assert property (reg_wr && reg_addr == 6'h30 && reg_wdata[7:6] == 2'h0 |-> ##2 !chan_a_pin_en)
      else $error("channel a enabled with mode off");
   a_off_mode_b: assert property (reg_wr && reg_addr == 6'h30 && reg_wdata[5:4] == 2'h0 |-> ##2 !chan_b_pin_en)
      else $error("channel b enabled with mode off");
   a_rsvd_mode_off: assert property (reg_wr && reg_addr == 6'h33 && reg_wdata[3] && !wml_reg[0]
      |-> ##2 (!chan_a_pin_en && !chan_b_pin_en)) else $error("pins enabled in reserved mode");
endmodule : tmw_timer8_checker

bind tmw_timer8 tmw_timer8_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dir_a(dir_a),
   .dir_b(dir_b), .chan_a_pin_en(chan_a_pin_en), .chan_b_pin_en(chan_b_pin_en));

/* File: tb/tmw_timer8_tb.sv */
// testbench for the timer waveform block: registers, modes, pins
// assumes tmw_timer8 with its checker bound in
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module tmw_timer8_tb;
   logic       clk_sys = 1'b0;
   logic       rst_n   = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       tick_pin = 1'b0;
   logic       dir_a = 1'b0;
   logic       dir_b = 1'b0;
   logic       wa, wb, ea, eb;
   int         n_mismatch = 0;
   int         samples_checked = 0;
   int         cycles = 0;
   int         ha, hb, ta, tb;
   logic [7:0] d;

   always #2.5 clk_sys = ~clk_sys;

   tmw_timer8 dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_pin(tick_pin), .dir_a(dir_a),
      .dir_b(dir_b), .chan_a_wave_out(wa), .chan_b_wave_out(wb), .chan_a_pin_en(ea), .chan_b_pin_en(eb));

   task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= v;
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      bus(1'b1, 1'b0, a, v);
      bus(1'b0, 1'b0, a, 8'h00);
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, a, 8'h00);
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wait_cyc

   // high samples of both outputs and toggles over n cycles
   task automatic duty(input int n);
      logic pa, pb;
      ha = 0; hb = 0; ta = 0; tb = 0;
      @(posedge clk_sys);
      #1;
      pa = wa;
      pb = wb;
      repeat (n) begin
         @(posedge clk_sys);
         #1;
         ha += (wa === 1'b1);
         hb += (wb === 1'b1);
         ta += (wa !== pa);
         tb += (wb !== pb);
         pa = wa;
         pb = wb;
      end
   endtask : duty

   task automatic t_regs;
      rd(6'h30, d); `CHK(d, 8'h00)
      bus(1'b1, 1'b0, 6'h30, 8'hFF);
      rd(6'h30, d); `CHK(d, 8'hF3)
      wr(6'h32, 8'h10);
      wait_cyc(20);
      rd(6'h32, d); `CHK(d, 8'h10)
      wr(6'h21, 8'hAA);
      rd(6'h21, d); `CHK(d, 8'h00)
      wr(6'h30, 8'h00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_nonpwm;
      dir_a <= 1'b1;
      dir_b <= 1'b1;
      wr(6'h36, 8'h05); wr(6'h3C, 8'h05); wr(6'h30, 8'hE0); wr(6'h33, 8'h01);
      wait_cyc(600);
      #1;
      `CHK(wa, 1'b1)
      `CHK(wb, 1'b0)
      `CHK(ea, 1'b1)
      `CHK(eb, 1'b1)
      wr(6'h30, 8'hB0);
      wait_cyc(600);
      #1;
      `CHK(wa, 1'b0)
      `CHK(wb, 1'b1)
      wr(6'h36, 8'h09); wr(6'h3C, 8'h04); wr(6'h30, 8'h52);
      wait_cyc(300);
      duty(200);
      `CHK(ta, 20)
      `CHK(tb, 20)
      @(posedge clk_sys);
      dir_a <= 1'b0;
      wait_cyc(2);
      #1;
      `CHK(ea, 1'b0)
      dir_a <= 1'b1;
      $display("test non-pwm done");
   endtask : t_nonpwm

   task automatic t_fast;
      wr(6'h36, 8'hFF); wr(6'h3C, 8'h80); wr(6'h30, 8'hA3);
      wait_cyc(600);
      duty(256);
      `CHK(ha, 256)
      `CHK(hb, 129)
      wr(6'h30, 8'hF3);
      wait_cyc(600);
      duty(256);
      `CHK(ha, 0)
      `CHK(hb, 127)
      wr(6'h30, 8'h13);
      wait_cyc(3);
      #1;
      `CHK(eb, 1'b0)
      wr(6'h30, 8'hA0); wr(6'h33, 8'h09);
      wait_cyc(3);
      #1;
      `CHK(ea, 1'b0)
      $display("test fast pwm done");
   endtask : t_fast

   task automatic t_phase;
      wr(6'h33, 8'h01); wr(6'h36, 8'hFF); wr(6'h3C, 8'h80); wr(6'h30, 8'hA1);
      wait_cyc(1100);
      duty(510);
      `CHK(ha, 510)
      `CHK(hb, 256)
      $display("test phase pwm done");
   endtask : t_phase

   task automatic t_ext;
      wr(6'h30, 8'h00); wr(6'h33, 8'h07); wr(6'h32, 8'h00);
      repeat (10) begin
         wait_cyc(4);
         tick_pin <= 1'b1;
         wait_cyc(4);
         tick_pin <= 1'b0;
      end
      wait_cyc(8);
      rd(6'h32, d); `CHK(d, 8'h0A)
      // counter idle now: flags from earlier modes stand, then clear
      rd(6'h38, d); `CHK(d, 8'h07)
      wr(6'h38, 8'h07);
      rd(6'h38, d); `CHK(d, 8'h00)
      // forced compare in normal mode clears A and raises no flag
      wr(6'h30, 8'h80);
      wr(6'h33, 8'h87);
      #1;
      `CHK(wa, 1'b0)
      rd(6'h38, d); `CHK(d, 8'h00)
      $display("test external tick done");
   endtask : t_ext

   task automatic complete_run;
      $display("checks made %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   initial begin
      wait_cyc(5);
      rst_n <= 1'b1;
      t_regs();
      t_nonpwm();
      t_fast();
      t_phase();
      t_ext();
      complete_run();
   end
endmodule : tmw_timer8_tb
